// ==== bls_consts.vh ====
// Timing constants and codes for the burner lockout sequencer
`ifndef BLS_CONSTS_VH
`define BLS_CONSTS_VH

// Clock rate and timebase tick (10 ms tick)
`define BLS_CLK_HZ 200000000
`define BLS_TICK_MS 10
`define BLS_TICK_CYC ((`BLS_CLK_HZ / 1000) * `BLS_TICK_MS)

// Sequence intervals in milliseconds
`define BLS_FAN_CHECK_MS 2500
`define BLS_QUICK_RETRY_MS 10000
`define BLS_AIR_WAIT_MS 60000
`define BLS_PREPURGE_MS 24000
`define BLS_STRAY_MS 5000
`define BLS_SAFETY_MS 3000
`define BLS_RESET_HOLD_MS 3000
`define BLS_LAMP_LIT_MS 10000
`define BLS_FLASH_ON_MS 300
`define BLS_FLASH_OFF_MS 300

// Intervals in timebase ticks
`define BLS_FAN_CHECK_T (`BLS_FAN_CHECK_MS / `BLS_TICK_MS)
`define BLS_QUICK_RETRY_T (`BLS_QUICK_RETRY_MS / `BLS_TICK_MS)
`define BLS_AIR_WAIT_T (`BLS_AIR_WAIT_MS / `BLS_TICK_MS)
`define BLS_PREPURGE_T (`BLS_PREPURGE_MS / `BLS_TICK_MS)
`define BLS_STRAY_T (`BLS_STRAY_MS / `BLS_TICK_MS)
`define BLS_SAFETY_T (`BLS_SAFETY_MS / `BLS_TICK_MS)
`define BLS_RESET_HOLD_T (`BLS_RESET_HOLD_MS / `BLS_TICK_MS)
`define BLS_LAMP_LIT_T (`BLS_LAMP_LIT_MS / `BLS_TICK_MS)
`define BLS_FLASH_ON_T (`BLS_FLASH_ON_MS / `BLS_TICK_MS)
`define BLS_FLASH_OFF_T (`BLS_FLASH_OFF_MS / `BLS_TICK_MS)

// Lockout cause codes, also the flash count shown in the dark phase
`define BLS_CAUSE_NONE 3'h0
`define BLS_CAUSE_SAFETY 3'h1
`define BLS_CAUSE_STRAY 3'h2
`define BLS_CAUSE_AIR_CLOSED 3'h3
`define BLS_CAUSE_AIR_TIMEOUT 3'h4
`define BLS_CAUSE_AIR_OPENED 3'h5
`define BLS_CAUSE_FLAME_LOSS 3'h6
`define BLS_CAUSE_MANUAL 3'h7

`endif

// ==== bls_tick_gen.v ====
// Timebase tick divider for the burner lockout sequencer
`timescale 1ns/10ps
`include "bls_consts.vh"
module bls_tick_gen #(
  parameter TICK_CYC = `BLS_TICK_CYC
) (
  input wire clk_sys_i,
  input wire reset_i,
  output reg tick_o
);
  reg [31:0] div_r;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      div_r <= 32'h0;
      tick_o <= 1'b0;
    end else if (div_r >= TICK_CYC - 1) begin
      div_r <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      div_r <= div_r + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ==== bls_lamp.v ====
// Lockout indicator: lit, broken every period by a flash code of the cause
`timescale 1ns/10ps
`include "bls_consts.vh"
module bls_lamp #(
  parameter LIT_T = `BLS_LAMP_LIT_T,
  parameter ON_T = `BLS_FLASH_ON_T,
  parameter OFF_T = `BLS_FLASH_OFF_T
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire tick_i,
  input wire locked_i,
  input wire [2:0] cause_i,
  output reg lamp_o
);
  reg [15:0] cnt_r;
  reg [3:0] pulse_r;
  reg dark_r;
  reg phase_on_r;

  always @(posedge clk_sys_i) begin
    if (reset_i || !locked_i) begin
      cnt_r <= 16'h0;
      pulse_r <= 4'h0;
      dark_r <= 1'b0;
      phase_on_r <= 1'b0;
      lamp_o <= 1'b0;
    end else if (tick_i) begin
      cnt_r <= cnt_r + 16'h1;
      if (!dark_r) begin
        lamp_o <= 1'b1;
        if (cnt_r >= LIT_T - 1) begin
          // Open with a dark gap, then one short light per cause step
          dark_r <= 1'b1;
          cnt_r <= 16'h0;
          pulse_r <= 4'h0;
          phase_on_r <= 1'b0;
          lamp_o <= 1'b0;
        end
      end else if (!phase_on_r) begin
        lamp_o <= 1'b0;
        if (cnt_r >= OFF_T - 1) begin
          cnt_r <= 16'h0;
          if (pulse_r == {1'b0, cause_i}) begin
            dark_r <= 1'b0;
            lamp_o <= 1'b1;
          end else begin
            phase_on_r <= 1'b1;
            lamp_o <= 1'b1;
          end
        end
      end else if (cnt_r >= ON_T - 1) begin
        cnt_r <= 16'h0;
        phase_on_r <= 1'b0;
        pulse_r <= pulse_r + 4'h1;
        lamp_o <= 1'b0;
      end
    end
  end
endmodule

// ==== bls_sequencer.v ====
// Burner start, supervision and lockout sequencer
//
// Summary of operation
// - No flame by safety end gives lockout
// - Flame loss while running gives lockout
// - Air contact opening in purge/run locks out
// - Air closed before start: fan, quick lockout
// - Quick lockout self-clears after ten seconds, retries
// - Lockout holds until local or remote reset
// - Power cycle keeps lockout, fan then relock
// - Air not closed in sixty seconds locks
// - Flame or open air at purge end locks
// - Remote terminal held active blocks start
// - Remote terminal equals built-in reset button
// - Reset held over three seconds forces lockout on release in air wait to run
// - Lockout lamp lit, periodic cause flash code
// - Stray light checked in window ending purge
`timescale 1ns/10ps
`include "bls_consts.vh"
module bls_sequencer #(
  parameter TICK_CYC = `BLS_TICK_CYC,
  parameter FAN_CHECK_T = `BLS_FAN_CHECK_T,
  parameter QUICK_RETRY_T = `BLS_QUICK_RETRY_T,
  parameter AIR_WAIT_T = `BLS_AIR_WAIT_T,
  parameter PREPURGE_T = `BLS_PREPURGE_T,
  parameter STRAY_T = `BLS_STRAY_T,
  parameter SAFETY_T = `BLS_SAFETY_T,
  parameter RESET_HOLD_T = `BLS_RESET_HOLD_T,
  parameter LAMP_LIT_T = `BLS_LAMP_LIT_T
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire heat_demand_i,
  input wire air_flow_proving_contact_i,
  input wire flame_i,
  input wire local_reset_i,
  input wire remote_reset_i,
  input wire [2:0] nv_cause_i,
  input wire nv_valid_i,
  output reg fan_o,
  output reg ignition_o,
  output reg fuel_valve_o,
  output reg locked_o,
  output reg alarm_o,
  output reg [2:0] cause_o,
  output reg nv_write_o,
  output reg [2:0] nv_data_o,
  output wire lamp_o
);

  // ==========================================================
  // States
  localparam ST_INIT = 4'h0;
  localparam ST_IDLE = 4'h1;
  localparam ST_FAN_CHECK = 4'h2;
  localparam ST_QUICK_LOCK = 4'h3;
  localparam ST_AIR_WAIT = 4'h4;
  localparam ST_PREPURGE = 4'h5;
  localparam ST_SAFETY = 4'h6;
  localparam ST_RUN = 4'h7;
  localparam ST_LOCKOUT = 4'h8;
  localparam ST_RELOCK_FAN = 4'h9;

  // ==========================================================
  // Timebase
  wire tick;

  bls_tick_gen #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [15:0] tmr_r;
  reg [15:0] hold_r;
  reg retry_r;
  reg retry_nxt;
  reg [2:0] cause_nxt;
  reg btn_prev_r;
  reg rst_prev_r;
  reg hold_long_r;
  reg manual_stop_r;

  wire btn = local_reset_i | remote_reset_i;
  wire btn_rel = btn_prev_r & ~btn;
  wire active = (state_r == ST_AIR_WAIT) || (state_r == ST_PREPURGE) ||
                (state_r == ST_SAFETY) || (state_r == ST_RUN);
  wire state_chg = (state_nxt != state_r);

  // ==========================================================
  // Reset button: press-release clears lockout, long press stops burner
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      btn_prev_r <= 1'b0;
      hold_r <= 16'h0;
      hold_long_r <= 1'b0;
      manual_stop_r <= 1'b0;
      rst_prev_r <= 1'b0;
    end else begin
      btn_prev_r <= btn;
      rst_prev_r <= remote_reset_i;
      if (!btn) begin
        hold_r <= 16'h0;
      end else if (tick && hold_r < RESET_HOLD_T) begin
        hold_r <= hold_r + 16'h1;
      end
      if (btn && hold_r >= RESET_HOLD_T) begin
        hold_long_r <= 1'b1;
      end else if (!btn) begin
        hold_long_r <= 1'b0;
      end
      manual_stop_r <= btn_rel & hold_long_r & active;
    end
  end

  // ==========================================================
  // Sequence timer, restarted on every state change
  always @(posedge clk_sys_i) begin
    if (reset_i || state_chg) begin
      tmr_r <= 16'h0;
    end else if (tick && tmr_r != 16'hffff) begin
      tmr_r <= tmr_r + 16'h1;
    end
  end

  // ==========================================================
  // Next state
  always @* begin
    state_nxt = state_r;
    cause_nxt = cause_o;
    retry_nxt = retry_r;
    case (state_r)
      ST_INIT: begin
        // Wait for the stored cause before any decision
        if (nv_valid_i) begin
          cause_nxt = nv_cause_i;
          if (nv_cause_i != `BLS_CAUSE_NONE) begin
            state_nxt = ST_RELOCK_FAN;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        // A permanently active remote terminal keeps the burner off
        if (heat_demand_i && !remote_reset_i) begin
          if (air_flow_proving_contact_i) begin
            state_nxt = ST_FAN_CHECK;
          end else begin
            state_nxt = ST_AIR_WAIT;
          end
        end
      end
      ST_FAN_CHECK: begin
        if (tmr_r >= FAN_CHECK_T) begin
          if (retry_r) begin
            state_nxt = ST_LOCKOUT;
            cause_nxt = `BLS_CAUSE_AIR_CLOSED;
            retry_nxt = 1'b0;
          end else begin
            state_nxt = ST_QUICK_LOCK;
          end
        end
      end
      ST_QUICK_LOCK: begin
        if (tmr_r >= QUICK_RETRY_T) begin
          retry_nxt = 1'b1;
          if (air_flow_proving_contact_i) begin
            state_nxt = ST_FAN_CHECK;
          end else begin
            state_nxt = ST_AIR_WAIT;
          end
        end
      end
      ST_AIR_WAIT: begin
        retry_nxt = 1'b0;
        if (air_flow_proving_contact_i) begin
          state_nxt = ST_PREPURGE;
        end else if (tmr_r >= AIR_WAIT_T) begin
          state_nxt = ST_LOCKOUT;
          cause_nxt = `BLS_CAUSE_AIR_TIMEOUT;
        end
      end
      ST_PREPURGE: begin
        if (!air_flow_proving_contact_i) begin
          state_nxt = ST_LOCKOUT;
          cause_nxt = `BLS_CAUSE_AIR_OPENED;
        end else if (flame_i && tmr_r >= PREPURGE_T - STRAY_T) begin
          state_nxt = ST_LOCKOUT;
          cause_nxt = `BLS_CAUSE_STRAY;
        end else if (tmr_r >= PREPURGE_T) begin
          state_nxt = ST_SAFETY;
        end
      end
      ST_SAFETY: begin
        if (!air_flow_proving_contact_i) begin
          state_nxt = ST_LOCKOUT;
          cause_nxt = `BLS_CAUSE_AIR_OPENED;
        end else if (tmr_r >= SAFETY_T) begin
          if (flame_i) begin
            state_nxt = ST_RUN;
          end else begin
            state_nxt = ST_LOCKOUT;
            cause_nxt = `BLS_CAUSE_SAFETY;
          end
        end
      end
      ST_RUN: begin
        if (!air_flow_proving_contact_i) begin
          state_nxt = ST_LOCKOUT;
          cause_nxt = `BLS_CAUSE_AIR_OPENED;
        end else if (!flame_i) begin
          state_nxt = ST_LOCKOUT;
          cause_nxt = `BLS_CAUSE_FLAME_LOSS;
        end else if (!heat_demand_i) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_LOCKOUT: begin
        // Only a fresh press clears it; power loss does not
        if (btn_rel && !hold_long_r) begin
          state_nxt = ST_IDLE;
          cause_nxt = `BLS_CAUSE_NONE;
        end
      end
      ST_RELOCK_FAN: begin
        if (tmr_r >= FAN_CHECK_T) begin
          state_nxt = ST_LOCKOUT;
        end
      end
      default: begin
        state_nxt = ST_LOCKOUT;
        cause_nxt = `BLS_CAUSE_MANUAL;
      end
    endcase
    if (manual_stop_r && active) begin
      state_nxt = ST_LOCKOUT;
      cause_nxt = `BLS_CAUSE_MANUAL;
    end
    if ((state_r == ST_AIR_WAIT || state_r == ST_PREPURGE) && !heat_demand_i &&
        state_nxt == state_r) begin
      state_nxt = ST_IDLE;
    end
  end

  // ==========================================================
  // State, outputs and non-volatile write
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= ST_INIT;
      retry_r <= 1'b0;
      cause_o <= `BLS_CAUSE_NONE;
      fan_o <= 1'b0;
      ignition_o <= 1'b0;
      fuel_valve_o <= 1'b0;
      locked_o <= 1'b0;
      alarm_o <= 1'b0;
      nv_write_o <= 1'b0;
      nv_data_o <= `BLS_CAUSE_NONE;
    end else begin
      state_r <= state_nxt;
      retry_r <= retry_nxt;
      cause_o <= cause_nxt;
      // Cause is written whenever it changes so it survives power loss
      nv_write_o <= (cause_nxt != cause_o);
      nv_data_o <= cause_nxt;
      fan_o <= (state_nxt == ST_FAN_CHECK) || (state_nxt == ST_RELOCK_FAN) ||
               (state_nxt == ST_AIR_WAIT) || (state_nxt == ST_PREPURGE) ||
               (state_nxt == ST_SAFETY) || (state_nxt == ST_RUN);
      ignition_o <= (state_nxt == ST_SAFETY);
      fuel_valve_o <= (state_nxt == ST_SAFETY) || (state_nxt == ST_RUN);
      locked_o <= (state_nxt == ST_LOCKOUT);
      alarm_o <= (state_nxt == ST_LOCKOUT) || (state_nxt == ST_QUICK_LOCK);
    end
  end

  // ==========================================================
  // Indicator
  bls_lamp #(
    .LIT_T(LAMP_LIT_T),
    .ON_T(`BLS_FLASH_ON_T),
    .OFF_T(`BLS_FLASH_OFF_T)
  ) u_lamp (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .locked_i(locked_o),
    .cause_i(cause_o),
    .lamp_o(lamp_o)
  );

endmodule

// ==== bls_sequencer_sva.sv ====
// Port assertions for the burner lockout sequencer
`timescale 1ns/10ps
module bls_sequencer_sva #(
  parameter TICK_CYC = 4,
  parameter QUICK_RETRY_T = 8,
  parameter FLASH_T = 30
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire heat_demand_i,
  input wire air_flow_proving_contact_i,
  input wire flame_i,
  input wire local_reset_i,
  input wire remote_reset_i,
  input wire nv_valid_i,
  input wire fan_o,
  input wire ignition_o,
  input wire fuel_valve_o,
  input wire locked_o,
  input wire alarm_o,
  input wire [2:0] cause_o,
  input wire lamp_o
);
  // ========
  // Helper counters
  reg [3:0] quiet_r;
  reg seen_r;
  reg [31:0] ql_r;
  reg [31:0] dark_r;
  // A recent button edge may legally change state, so run checks wait for quiet inputs
  wire run_w = fuel_valve_o && !ignition_o && heat_demand_i && quiet_r > 4'h3;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      quiet_r <= 4'h0;
      seen_r <= 1'b0;
      ql_r <= 32'h0;
      dark_r <= 32'h0;
    end else begin
      quiet_r <= (local_reset_i | remote_reset_i) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
      seen_r <= seen_r | nv_valid_i;
      ql_r <= (alarm_o & !locked_o) ? ql_r + 32'h1 : 32'h0;
      dark_r <= (locked_o & !lamp_o) ? dark_r + 32'h1 : 32'h0;
    end
  end
  // ========
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_lock_holds: assert property (locked_o && quiet_r > 4'h3 |=> locked_o && $stable(cause_o))
    else $error("lockout left or cause changed without reset");
  a_lock_safe: assert property (locked_o |-> !fuel_valve_o && !ignition_o)
    else $error("fuel or ignition on in lockout");
  a_remote_blocks: assert property (!fan_o && !locked_o && remote_reset_i && $past(remote_reset_i)
    |=> !fan_o)
    else $error("start while remote terminal held");
  a_air_open_run: assert property (run_w && flame_i && !air_flow_proving_contact_i
    |=> ##[0:2] locked_o && cause_o == 3'h5)
    else $error("air contact open in run without lockout");
  a_flame_loss: assert property (run_w && air_flow_proving_contact_i && !flame_i
    |=> ##[0:2] locked_o && cause_o == 3'h6)
    else $error("flame loss in run without lockout");
  a_safety_end: assert property ($fell(ignition_o) && heat_demand_i && air_flow_proving_contact_i
    && !flame_i && !$past(flame_i) && quiet_r > 4'h3 |-> ##[0:2] locked_o && cause_o == 3'h1)
    else $error("safety time ended without flame and no lockout");
  a_init_waits: assert property (!seen_r |-> !fan_o && !locked_o)
    else $error("left initial state before stored cause valid");
  a_quick_bound: assert property (ql_r <= QUICK_RETRY_T * TICK_CYC + TICK_CYC + 4)
    else $error("quick lockout not cleared in time");
  a_lamp_dark: assert property (dark_r <= FLASH_T * TICK_CYC + TICK_CYC + 4)
    else $error("lockout lamp dark too long");
endmodule
bind bls_sequencer bls_sequencer_sva #(.TICK_CYC(TICK_CYC), .QUICK_RETRY_T(QUICK_RETRY_T))
  i_bls_sequencer_sva (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .heat_demand_i(heat_demand_i),
  .air_flow_proving_contact_i(air_flow_proving_contact_i), .flame_i(flame_i),
  .local_reset_i(local_reset_i), .remote_reset_i(remote_reset_i), .nv_valid_i(nv_valid_i),
  .fan_o(fan_o), .ignition_o(ignition_o), .fuel_valve_o(fuel_valve_o), .locked_o(locked_o),
  .alarm_o(alarm_o), .cause_o(cause_o), .lamp_o(lamp_o));

// ==== bls_plant.sv ====
// Far-side model: air switch, flame detector and non-volatile cause store
`timescale 1ns/10ps
module bls_plant (
  input wire clk_sys_i,
  input wire reset_i,
  input wire fan_i,
  input wire fuel_valve_i,
  input wire nv_write_i,
  input wire [2:0] nv_data_i,
  input wire weld_i,
  input wire air_fail_i,
  input wire flame_en_i,
  input wire stray_i,
  input wire [3:0] air_dly_i,
  output reg air_o = 1'b0,
  output reg flame_o = 1'b0,
  output reg [2:0] nv_cause_o = 3'h7,
  output reg nv_valid_o = 1'b0
);
  reg [3:0] spin_r = 4'h0;
  reg [2:0] store_r = 3'h0;
  reg [1:0] wake_r = 2'h0;
  always @(posedge clk_sys_i) begin
    spin_r <= fan_i ? spin_r + {3'h0, spin_r != 4'hf} : 4'h0;
    // A welded contact reads closed whatever the fan does
    air_o <= weld_i | (fan_i & !air_fail_i & spin_r >= air_dly_i);
    flame_o <= (stray_i & fan_i) | (flame_en_i & fuel_valve_i);
    // The store ignores reset so a lockout survives a power cycle
    if (nv_write_i) store_r <= nv_data_i;
    wake_r <= reset_i ? 2'h0 : wake_r + {1'b0, wake_r != 2'h3};
    nv_valid_o <= !reset_i && wake_r == 2'h3;
    nv_cause_o <= (wake_r == 2'h3) ? store_r : ~store_r;
  end
endmodule

// ==== bls_sequencer_test.sv ====
// Self-checking bench for the burner lockout sequencer
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, s); end end
`define WAIT(c, n) begin int k; k = 0; while (!(c) && k < (n)) begin \
  @(posedge clk_sys_i); k++; end end
module bls_sequencer_test;
  localparam TK = 4;
  localparam FC = 5;
  localparam QR = 8;
  localparam RH = 6;
  localparam LIT = 10;
  int error_cnt = 0;
  int comparisons = 0;
  reg clk_sys_i = 1'b0;
  reg reset_i = 1'b1;
  reg heat_demand = 1'b0, local_rst = 1'b0, remote_rst = 1'b0;
  reg weld = 1'b0, air_fail = 1'b0, flame_en = 1'b1, stray = 1'b0;
  reg [3:0] air_dly = 4'h2;
  wire air, flame, nv_valid, nv_write, fan_o, ignition_o, fuel_valve_o, locked_o, alarm_o, lamp_o;
  wire [2:0] nv_cause, nv_data, cause_o;
  always #2.5 clk_sys_i = ~clk_sys_i;
  bls_sequencer #(.TICK_CYC(TK), .FAN_CHECK_T(FC), .QUICK_RETRY_T(QR), .AIR_WAIT_T(20),
    .PREPURGE_T(12), .STRAY_T(4), .SAFETY_T(6), .RESET_HOLD_T(RH), .LAMP_LIT_T(LIT))
  i_bls_sequencer (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .heat_demand_i(heat_demand),
    .air_flow_proving_contact_i(air), .flame_i(flame), .local_reset_i(local_rst),
    .remote_reset_i(remote_rst), .nv_cause_i(nv_cause), .nv_valid_i(nv_valid), .fan_o(fan_o),
    .ignition_o(ignition_o), .fuel_valve_o(fuel_valve_o), .locked_o(locked_o),
    .alarm_o(alarm_o), .cause_o(cause_o), .nv_write_o(nv_write), .nv_data_o(nv_data),
    .lamp_o(lamp_o));
  bls_plant i_bls_plant (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .fan_i(fan_o),
    .fuel_valve_i(fuel_valve_o), .nv_write_i(nv_write), .nv_data_i(nv_data), .weld_i(weld),
    .air_fail_i(air_fail), .flame_en_i(flame_en), .stray_i(stray), .air_dly_i(air_dly),
    .air_o(air), .flame_o(flame), .nv_cause_o(nv_cause), .nv_valid_o(nv_valid));
  // ========
  // Expectations and tasks
  function automatic [2:0] exp_cause(input int m);
    exp_cause = m < 4 ? 3'(m + 1) : (m == 4 ? 3'h6 : (m == 5 ? 3'h5 : 3'h7));
  endfunction
  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Demand drops first so the cleared sequencer rests idle until the next scenario
  task automatic clear_lock;
    heat_demand <= 1'b0;
    if ($urandom_range(0, 1)) local_rst <= 1'b1;
    else remote_rst <= 1'b1;
    repeat ($urandom_range(2, 10)) @(posedge clk_sys_i);
    local_rst <= 1'b0;
    remote_rst <= 1'b0;
    `WAIT(!locked_o, 20)
    `CHK("locked", 1'b0, locked_o)
  endtask
  task automatic lockrun(input int m);
    int n;
    weld <= m == 2;
    air_fail <= m == 3;
    flame_en <= m != 0;
    stray <= m == 1;
    air_dly <= 4'($urandom_range(0, 15));
    repeat (4) @(posedge clk_sys_i);
    heat_demand <= 1'b1;
    if (m > 3) begin
      `WAIT(fuel_valve_o && !ignition_o, 400)
      repeat ($urandom_range(2, 30)) @(posedge clk_sys_i);
      if (m == 4) flame_en <= 1'b0;
      else if (m == 5) air_fail <= 1'b1;
      else local_rst <= 1'b1;
      repeat (m == 6 ? RH * TK + $urandom_range(4, 20) : 1) @(posedge clk_sys_i);
      local_rst <= 1'b0;
    end
    `WAIT(locked_o, 600)
    `CHK("cause", exp_cause(m), cause_o)
    repeat ($urandom_range(8, 40)) @(posedge clk_sys_i);
    `CHK("held", {1'b1, exp_cause(m)}, {locked_o, cause_o})
    if (m == 0) begin
      `WAIT(!lamp_o, LIT * TK + TK + 20)
      `CHK("lamp_dark", 1'b0, lamp_o)
      `WAIT(lamp_o, 30 * TK + TK + 8)
      `CHK("lamp_lit", 1'b1, lamp_o)
    end
    if (m == 2) begin
      reset_i <= 1'b1;
      repeat (16) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      `WAIT(fan_o, 30)
      n = 0;
      while (fan_o === 1'b1 && n < 100) begin
        @(posedge clk_sys_i);
        n++;
      end
      `CHK("fan_time", 1'b1, n >= FC * TK - TK && n <= FC * TK + TK + 2)
      `WAIT(locked_o, 4)
      `CHK("relock", {1'b1, 3'h3}, {locked_o, cause_o})
    end
  endtask
  // ========
  // Main sequence and watchdog
  initial begin
    int r;
    void'($urandom(32'h514ca0d2));
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    `CHK("reset_out", 4'h0, {fan_o, cause_o})
    for (r = 0; r < 14; r++) begin
      lockrun(r % 7);
      clear_lock;
    end
    weld <= 1'b1;
    flame_en <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    heat_demand <= 1'b1;
    `WAIT(alarm_o, FC * TK + 40)
    `CHK("quick", 2'h1, {locked_o, alarm_o})
    weld <= 1'b0;
    `WAIT(fuel_valve_o && !ignition_o, QR * TK + 400)
    `CHK("restart", 2'h1, {locked_o, fuel_valve_o})
    heat_demand <= 1'b0;
    `WAIT(!fan_o, 20)
    `CHK("shutdown", 1'b0, fan_o)
    remote_rst <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    heat_demand <= 1'b1;
    repeat (150) @(posedge clk_sys_i);
    `CHK("blocked", 1'b0, fan_o)
    finish_test;
  end
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    error_cnt++;
    $display("[ERR] watchdog expected done seen running");
    finish_test;
  end
endmodule
